// ### rtc_ctrl_pkg.sv
// constants of the rtc register block
`default_nettype none
package rtc_ctrl_pkg;
    // register offsets
    localparam logic [7:0] RATE_CTRL_OFS  = 8'h0A;
    localparam logic [7:0] INTR_CTRL_OFS  = 8'h0B;
    localparam logic [7:0] EVENT_FLAG_OFS = 8'h0C;
    localparam logic [7:0] BACKUP_OFS     = 8'h0D;
    // rate/clock-source register layout
    localparam int         PENDING_BIT     = 7;
    localparam int         SRC_MSB         = 6;
    localparam int         SRC_LSB         = 4;
    localparam int         RATE_MSB        = 3;
    localparam logic [2:0] SRC_RUN         = 3'h2;
    localparam logic [1:0] SRC_OSC_ONLY    = 2'h3;
    localparam logic [6:0] RATE_CTRL_RESET = 7'h00;
    // interrupt/format register layout
    localparam int         HOLD_BIT        = 7;
    localparam int         PER_EN_BIT      = 6;
    localparam int         ALM_EN_BIT      = 5;
    localparam int         UPD_EN_BIT      = 4;
    localparam int         SQ_EN_BIT       = 3;
    localparam int         FMT_BIT         = 2;
    localparam int         HOUR_BIT        = 1;
    localparam int         DST_BIT         = 0;
    localparam logic [7:0] INTR_CTRL_RESET = 8'h00;
    // event register layout
    localparam int         IRQ_FLAG_BIT    = 7;
    localparam int         PER_FLAG_BIT    = 6;
    localparam int         ALM_FLAG_BIT    = 5;
    localparam int         UPD_FLAG_BIT    = 4;
    localparam int         BACKUP_BIT      = 7;
    // divider tap per rate code
    localparam logic [3:0] RATE_NONE       = 4'h0;
    localparam logic [3:0] RATE_ALIAS_256  = 4'h1;
    localparam logic [3:0] RATE_ALIAS_128  = 4'h2;
    localparam logic [3:0] TAP_256HZ       = 4'h6;
    localparam logic [3:0] TAP_128HZ       = 4'h7;
    localparam logic [3:0] TAP_OFFSET      = 4'h2;
    // time base
    localparam int         CLK_HZ          = 125_000_000;
    localparam int         XTAL_HZ         = 32_768;
    localparam int         ACC_W           = 27;
    localparam int         DIV_W           = 15;
    localparam int         CLK_PERIOD_NS   = 8;
    localparam int         UPD_CYCLE_NS    = 1000;
    localparam int         UPD_CYCLE_CLKS  = (UPD_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         FIRST_UPD_MS    = 500;
    localparam int         FIRST_UPD_TICKS = FIRST_UPD_MS * XTAL_HZ / 1000;
    localparam int         PRE_UPD_US      = 244;
    localparam int         PRE_UPD_TICKS   = (PRE_UPD_US * XTAL_HZ + 999_999) / 1_000_000;
    localparam logic [DIV_W-1:0] UPD_AT    = DIV_W'(FIRST_UPD_TICKS - 1);
    localparam logic [DIV_W-1:0] PEND_AT   = DIV_W'(FIRST_UPD_TICKS - PRE_UPD_TICKS - 1);
    // update sequencer states
    typedef enum logic [1:0] {UPD_IDLE, UPD_WAIT, UPD_BUSY} upd_state_type;
endpackage
`default_nettype wire

// ### xtal_divider.sv
// crystal tick generator and divider chain
`default_nettype none
module xtal_divider (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic                            osc_run,
    input  wire logic                            div_run,
    output logic                                 xtal_tick,
    output logic [rtc_ctrl_pkg::DIV_W-1:0]       div_count
);
    ////////////////////////////////////////////////////////////////
    // phase accumulator: mean rate is the crystal's
    logic [rtc_ctrl_pkg::ACC_W-1:0] acc_q;   // fractional phase
    logic [rtc_ctrl_pkg::ACC_W-1:0] acc_sum; // phase plus one step
    logic                           wrap;    // phase crossed a period
    logic [rtc_ctrl_pkg::ACC_W-1:0] acc_d;

    assign acc_sum = acc_q + rtc_ctrl_pkg::ACC_W'(rtc_ctrl_pkg::XTAL_HZ);
    assign wrap    = acc_sum >= rtc_ctrl_pkg::ACC_W'(rtc_ctrl_pkg::CLK_HZ);
    assign acc_d   = wrap ? acc_sum - rtc_ctrl_pkg::ACC_W'(rtc_ctrl_pkg::CLK_HZ) : acc_sum;

    // no ticks while stopped
    always_ff @(posedge clk) begin
        if (!rst_n || !osc_run) begin
            acc_q     <= '0;
            xtal_tick <= 1'b0;
        end else begin
            acc_q     <= acc_d;
            xtal_tick <= wrap;
        end
    end

    ////////////////////////////////////////////////////////////////
    // held at zero while off, so a new run
    // pattern starts a fresh half second
    always_ff @(posedge clk) begin
        if (!rst_n || !div_run) begin
            div_count <= '0;
        end else if (xtal_tick) begin
            div_count <= div_count + 1'b1;
        end
    end
endmodule // xtal_divider
`default_nettype wire

// ### rtc_control_status_regs.sv
// real-time clock control and status registers
`default_nettype none
// Overview of operation
// RULE_01 - registers reachable during update
// RULE_02 - four-bit rate select, thirteen rates
// RULE_03 - source 010 runs all; 11X oscillator only
// RULE_04 - first update half second after run
// RULE_05 - read-only pending bit brackets each update
// RULE_06 - hold forces pending bit clear
// RULE_07 - second register fully read/write
// RULE_08 - reset pin clears enables and flags
// RULE_09 - october fall-back via summer-time enable
// RULE_10 - april spring-forward via summer-time enable
// RULE_11 - hour mode: one is 24-hour
// RULE_12 - number format: one is binary
// RULE_13 - square output driven or held low
// RULE_14 - hold clears update interrupt enable
// RULE_15 - hold stops buffer copying
// RULE_16 - event enables gate requests
// RULE_17 - event register read-only, low nibble zero
// RULE_18 - update flag set per update, read-cleared
// RULE_19 - alarm flag set on match, read-cleared
// RULE_20 - periodic flag set per interval, read-cleared
// RULE_21 - request flag from enabled flags
// RULE_22 - backup register: top bit shows validity
// RULE_23 - event read releases interrupt pin
// RULE_24 - rate codes map to fixed frequencies
// RULE_25 - update request needs enable and no hold
// RULE_26 - address phase first; read-only writes ignored
module rtc_control_status_regs (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       reset_pin_n,
    input  wire logic       chip_sel_n,
    input  wire logic       addr_strobe,
    input  wire logic       read_n,
    input  wire logic       write_n,
    input  wire logic [7:0] ad_in,
    output logic      [7:0] ad_out,
    output logic            ad_oe,
    output logic            irq_n_out,
    output logic            irq_n_oe,
    output logic            square_wave_out,
    input  wire logic       alarm_match,
    input  wire logic       backup_valid,
    output logic            osc_run,
    output logic            div_run,
    output logic            update_strobe,
    output logic            buffer_copy_strobe,
    output logic            hour_mode_sel,
    output logic            number_format_sel,
    output logic            summer_time_en
);
    ////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0] addr_q;         // latched register address
    logic       as_q;           // address strobe, last cycle
    logic       rd_cyc_q;       // read seen last cycle
    logic       wr_cyc_q;       // write seen last cycle
    logic [7:0] wdata_q;        // write data
    logic [6:0] rate_ctrl_q;    // source and rate fields
    logic [7:0] intr_ctrl_q;    // enables and format bits
    logic       per_flag_q;     // periodic event flag
    logic       alm_flag_q;     // alarm event flag
    logic       upd_flag_q;     // update-done event flag
    logic       irq_flag_q;     // interrupt request flag
    logic       backup_q;       // sampled backup-valid level
    logic       tap_q;          // divider tap, last cycle
    logic [6:0] upd_cnt_q;      // clocks into the update cycle
    rtc_ctrl_pkg::upd_state_type upd_state_q;
    rtc_ctrl_pkg::upd_state_type upd_state_d;

    logic                           xtal_tick;
    logic [rtc_ctrl_pkg::DIV_W-1:0] div_count;

    ////////////////////////////////////////////////////////////////
    // divider tap for a rate code
    function automatic logic [3:0] rate_tap(input logic [3:0] code);
        logic [3:0] tap;
        tap = code - rtc_ctrl_pkg::TAP_OFFSET;
        if (code == rtc_ctrl_pkg::RATE_ALIAS_256) begin
            tap = rtc_ctrl_pkg::TAP_256HZ;
        end else if (code == rtc_ctrl_pkg::RATE_ALIAS_128) begin
            tap = rtc_ctrl_pkg::TAP_128HZ;
        end
        return tap;
    endfunction

    ////////////////////////////////////////////////////////////////
    // bus decode
    wire       sel         = !chip_sel_n;
    wire       as_fall     = as_q && !addr_strobe;
    wire       rd_cyc      = sel && !read_n;
    wire       wr_cyc      = sel && !write_n;
    wire       wr_end      = wr_cyc_q && write_n;       // RULE_26
    wire       rd_end      = rd_cyc_q && read_n;
    wire       hit_rate    = addr_q == rtc_ctrl_pkg::RATE_CTRL_OFS;
    wire       hit_intr    = addr_q == rtc_ctrl_pkg::INTR_CTRL_OFS;
    wire       hit_event   = addr_q == rtc_ctrl_pkg::EVENT_FLAG_OFS;
    wire       hit_backup  = addr_q == rtc_ctrl_pkg::BACKUP_OFS;
    wire       mapped      = hit_rate || hit_intr || hit_event || hit_backup;
    // no write path to event or backup
    wire       wr_rate     = wr_end && hit_rate;        // RULE_26
    wire       wr_intr     = wr_end && hit_intr;        // RULE_26
    wire       event_clr   = rd_end && hit_event;       // RULE_18 RULE_19 RULE_20 RULE_21
    wire       pin_reset   = !reset_pin_n;

    ////////////////////////////////////////////////////////////////
    // clock-source and rate decode
    wire [2:0] src_field   = rate_ctrl_q[rtc_ctrl_pkg::SRC_MSB:rtc_ctrl_pkg::SRC_LSB];
    wire [3:0] rate_sel    = rate_ctrl_q[rtc_ctrl_pkg::RATE_MSB:0];
    wire       src_full    = src_field == rtc_ctrl_pkg::SRC_RUN;           // RULE_03
    wire       src_osc     = src_field[2:1] == rtc_ctrl_pkg::SRC_OSC_ONLY; // RULE_03
    wire       rate_on     = rate_sel != rtc_ctrl_pkg::RATE_NONE;          // RULE_24
    wire [3:0] tap_idx     = rate_tap(rate_sel);                           // RULE_02 RULE_24
    wire       tap_bit     = rate_on && div_count[tap_idx];
    wire       per_event   = tap_bit && !tap_q;                            // RULE_20

    ////////////////////////////////////////////////////////////////
    // control bits
    wire       hold        = intr_ctrl_q[rtc_ctrl_pkg::HOLD_BIT];
    wire       per_en      = intr_ctrl_q[rtc_ctrl_pkg::PER_EN_BIT];
    wire       alm_en      = intr_ctrl_q[rtc_ctrl_pkg::ALM_EN_BIT];
    wire       upd_en      = intr_ctrl_q[rtc_ctrl_pkg::UPD_EN_BIT];
    wire       sq_en       = intr_ctrl_q[rtc_ctrl_pkg::SQ_EN_BIT];

    ////////////////////////////////////////////////////////////////
    // update sequencer decode
    wire       pend_start  = xtal_tick && div_count == rtc_ctrl_pkg::PEND_AT;
    wire       upd_start   = xtal_tick && div_count == rtc_ctrl_pkg::UPD_AT;  // RULE_04
    wire       upd_last    = upd_cnt_q == 7'(rtc_ctrl_pkg::UPD_CYCLE_CLKS - 1);
    wire       upd_done    = upd_state_q == rtc_ctrl_pkg::UPD_BUSY && upd_last;
    wire       pending     = upd_state_q != rtc_ctrl_pkg::UPD_IDLE && !hold; // RULE_05 RULE_06

    ////////////////////////////////////////////////////////////////
    // event flags: set wins over a clearing read
    wire       per_flag_d  = per_event || (per_flag_q && !event_clr);                // RULE_20
    wire       alm_flag_d  = (upd_done && alarm_match) || (alm_flag_q && !event_clr); // RULE_19
    wire       upd_flag_d  = upd_done || (upd_flag_q && !event_clr);                 // RULE_18
    // update requests also need hold low
    wire       irq_hit     = (per_en && per_flag_d) || (alm_en && alm_flag_d)
                           || (upd_en && !hold && upd_flag_d);                    // RULE_16 RULE_25
    wire       irq_flag_d  = irq_hit || (irq_flag_q && !event_clr);                  // RULE_21

    ////////////////////////////////////////////////////////////////
    // read data mux
    wire [7:0] rd_rate     = {pending, rate_ctrl_q};                                 // RULE_05
    wire [7:0] rd_event    = {irq_flag_q, per_flag_q, alm_flag_q, upd_flag_q, 4'h0}; // RULE_17
    wire [7:0] rd_backup   = {backup_q, 7'h00};                                      // RULE_22
    wire [7:0] rd_data     = hit_rate  ? rd_rate
                           : hit_intr  ? intr_ctrl_q                                 // RULE_07
                           : hit_event ? rd_event
                           : hit_backup ? rd_backup : 8'h00;

    ////////////////////////////////////////////////////////////////
    // written control values
    // pending bit is status only: write bit 7 dropped
    wire [6:0] rate_ctrl_d = wr_rate ? wdata_q[6:0] : rate_ctrl_q;        // RULE_05
    wire [7:0] intr_wr     = wr_intr ? wdata_q : intr_ctrl_q;             // RULE_07
    // hold clears the update enable
    wire       upd_en_d    = intr_wr[rtc_ctrl_pkg::UPD_EN_BIT]
                             && !intr_wr[rtc_ctrl_pkg::HOLD_BIT];         // RULE_14

    ////////////////////////////////////////////////////////////////
    // time base
    xtal_divider u_divider (
        .clk       (clk),
        .rst_n     (rst_n),
        .osc_run   (osc_run),
        .div_run   (div_run),
        .xtal_tick (xtal_tick),
        .div_count (div_count)
    );

    ////////////////////////////////////////////////////////////////
    // bus phases; address taken on strobe fall
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            as_q     <= 1'b0;
            rd_cyc_q <= 1'b0;
            wr_cyc_q <= 1'b0;
        end else begin
            as_q     <= addr_strobe;
            rd_cyc_q <= rd_cyc;
            wr_cyc_q <= wr_cyc;
        end
    end

    // address and write data capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_q  <= 8'h00;
            wdata_q <= 8'h00;
        end else begin
            if (as_fall) begin
                addr_q <= ad_in;                  // RULE_26
            end
            if (wr_cyc) begin
                wdata_q <= ad_in;
            end
        end
    end

    // read data one clock after the strobe;
    // never gated by the update cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ad_out <= 8'h00;
            ad_oe  <= 1'b0;
        end else begin
            ad_out <= rd_data;                    // RULE_01
            ad_oe  <= rd_cyc && mapped;           // RULE_01
        end
    end

    ////////////////////////////////////////////////////////////////
    // rate register: reset pin leaves it alone
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_ctrl_q <= rtc_ctrl_pkg::RATE_CTRL_RESET;
        end else begin
            rate_ctrl_q <= rate_ctrl_d;           // RULE_02 RULE_03
        end
    end

    // control register; reset pin clears enables only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            intr_ctrl_q <= rtc_ctrl_pkg::INTR_CTRL_RESET;
        end else begin
            intr_ctrl_q                        <= intr_wr;
            intr_ctrl_q[rtc_ctrl_pkg::UPD_EN_BIT] <= upd_en_d && !pin_reset;  // RULE_14 RULE_08
            if (pin_reset) begin
                intr_ctrl_q[rtc_ctrl_pkg::PER_EN_BIT] <= 1'b0;          // RULE_08
                intr_ctrl_q[rtc_ctrl_pkg::ALM_EN_BIT] <= 1'b0;          // RULE_08
                intr_ctrl_q[rtc_ctrl_pkg::SQ_EN_BIT]  <= 1'b0;          // RULE_08
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // event flags and request flag
    always_ff @(posedge clk) begin
        if (!rst_n || pin_reset) begin
            per_flag_q <= 1'b0;                   // RULE_08
            alm_flag_q <= 1'b0;
            upd_flag_q <= 1'b0;
            irq_flag_q <= 1'b0;
        end else begin
            per_flag_q <= per_flag_d;             // RULE_20
            alm_flag_q <= alm_flag_d;             // RULE_19
            upd_flag_q <= upd_flag_d;             // RULE_18
            irq_flag_q <= irq_flag_d;             // RULE_21
        end
    end

    // request pin tracks the flag, so the
    // clearing read frees it on that edge
    always_ff @(posedge clk) begin
        if (!rst_n || pin_reset) begin
            irq_n_oe <= 1'b0;
        end else begin
            irq_n_oe <= irq_flag_d;               // RULE_23
        end
    end

    // request pin only ever pulls low
    always_ff @(posedge clk) begin
        irq_n_out <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // square wave and periodic edge tracking
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tap_q           <= 1'b0;
            square_wave_out <= 1'b0;
        end else begin
            tap_q           <= tap_bit;
            square_wave_out <= sq_en && tap_bit;  // RULE_13
        end
    end

    ////////////////////////////////////////////////////////////////
    // update sequencer next state
    always_comb begin
        upd_state_d = upd_state_q;
        case (upd_state_q)
            rtc_ctrl_pkg::UPD_IDLE: begin
                if (pend_start) begin
                    upd_state_d = rtc_ctrl_pkg::UPD_WAIT;
                end
            end
            rtc_ctrl_pkg::UPD_WAIT: begin
                if (upd_start) begin
                    upd_state_d = rtc_ctrl_pkg::UPD_BUSY;
                end
            end
            rtc_ctrl_pkg::UPD_BUSY: begin
                if (upd_last) begin
                    upd_state_d = rtc_ctrl_pkg::UPD_IDLE;
                end
            end
            default: begin
                upd_state_d = rtc_ctrl_pkg::UPD_IDLE;
            end
        endcase
    end

    // stopping the divider drops any update
    always_ff @(posedge clk) begin
        if (!rst_n || !div_run) begin
            upd_state_q <= rtc_ctrl_pkg::UPD_IDLE;
            upd_cnt_q   <= 7'h00;
        end else begin
            upd_state_q <= upd_state_d;           // RULE_05
            upd_cnt_q   <= (upd_state_q == rtc_ctrl_pkg::UPD_BUSY) ? upd_cnt_q + 1'b1 : 7'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // strobes to counters and user buffer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            update_strobe      <= 1'b0;
            buffer_copy_strobe <= 1'b0;
        end else begin
            update_strobe      <= upd_start && upd_state_q == rtc_ctrl_pkg::UPD_WAIT;
            buffer_copy_strobe <= upd_done && !hold;  // RULE_15
        end
    end

    ////////////////////////////////////////////////////////////////
    // registered control levels for the counters and the sampled backup-valid level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_run           <= 1'b0;
            div_run           <= 1'b0;
            hour_mode_sel     <= 1'b0;
            number_format_sel <= 1'b0;
            summer_time_en    <= 1'b0;
            backup_q          <= 1'b0;
        end else begin
            osc_run           <= src_full || src_osc;                          // RULE_03
            div_run           <= src_full;                                     // RULE_03 RULE_04
            hour_mode_sel     <= intr_ctrl_q[rtc_ctrl_pkg::HOUR_BIT];          // RULE_11
            number_format_sel <= intr_ctrl_q[rtc_ctrl_pkg::FMT_BIT];           // RULE_12
            summer_time_en    <= intr_ctrl_q[rtc_ctrl_pkg::DST_BIT];           // RULE_09 RULE_10
            backup_q          <= backup_valid;                                 // RULE_22
        end
    end
endmodule // rtc_control_status_regs
`default_nettype wire

// ### rtc_regs_chk.sv
// port checks of the rtc register block
`default_nettype none
module rtc_regs_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reset_pin_n,
    input wire logic       chip_sel_n,
    input wire logic       addr_strobe,
    input wire logic       read_n,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic       ad_oe,
    input wire logic       irq_n_out,
    input wire logic       irq_n_oe,
    input wire logic       square_wave_out,
    input wire logic       osc_run,
    input wire logic       div_run,
    input wire logic       update_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       as_q;   // strobe level at the last edge
    logic [7:0] addr_q; // mirror of the latched address
    logic       rd_q;   // event register read seen last edge
    wire        rd_on  = !chip_sel_n && !read_n;
    wire        mapped = addr_q >= rtc_ctrl_pkg::RATE_CTRL_OFS && addr_q <= rtc_ctrl_pkg::BACKUP_OFS;
    wire        ev_sel = addr_q == rtc_ctrl_pkg::EVENT_FLAG_OFS;
    wire        rd_end = rd_q && read_n;
    // mirror of the address latch
    always_ff @(posedge clk) begin
        as_q   <= addr_strobe;
        addr_q <= (as_q && !addr_strobe) ? ad_in : addr_q;
        rd_q   <= rd_on && ev_sel;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // mapped read held two edges
    sequence rd_held;
        rd_on && mapped ##1 rd_on && mapped;
    endsequence
    div_osc_a: assert property (div_run |-> osc_run)
        else $error("divider without oscillator");
    rd_drive_a: assert property (rd_held |=> ad_oe)
        else $error("read not driven");
    drive_cause_a: assert property (ad_oe |-> $past(rd_on && mapped))
        else $error("stray bus drive");
    flag_nibble_a: assert property (ad_oe && ev_sel |-> ad_out[3:0] == 4'h0)
        else $error("event low bits set");
    backup_zero_a: assert property (ad_oe && addr_q == rtc_ctrl_pkg::BACKUP_OFS |-> ad_out[6:0] == 7'h00)
        else $error("backup low bits set");
    irq_release_a: assert property ($fell(irq_n_oe) |-> $past(rd_end) || $past(rd_end, 2) || $past(!reset_pin_n))
        else $error("stray irq release");
    irq_level_a: assert property (irq_n_oe |-> !irq_n_out)
        else $error("irq level high");
    pin_reset_a: assert property (!reset_pin_n |=> !irq_n_oe)
        else $error("irq kept by reset pin");
    reset_quiet_a: assert property ($rose(rst_n) |-> !ad_oe && !irq_n_oe && !osc_run && !square_wave_out)
        else $error("busy after reset");
    upd_run_a: assert property (update_strobe |-> div_run)
        else $error("update while stopped");
endmodule // rtc_regs_chk
bind rtc_control_status_regs rtc_regs_chk chk (.clk, .rst_n, .reset_pin_n, .chip_sel_n, .addr_strobe, .read_n,
    .ad_in, .ad_out, .ad_oe, .irq_n_out, .irq_n_oe, .square_wave_out, .osc_run, .div_run, .update_strobe);
`default_nettype wire

// ### host_bus_model.sv
// host model on the multiplexed bus
`default_nettype none
module host_bus_model (
    input  wire logic       clk,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    output logic            chip_sel_n,
    output logic            addr_strobe,
    output logic            read_n,
    output logic            write_n,
    output logic      [7:0] ad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv; // last byte the host put out
    logic       hoe; // host drives the bus
    // released bus shows the inverse byte: no stale data
    assign ad_in = ad_oe ? ad_out : (hoe ? drv : ~drv);
    initial {chip_sel_n, read_n, write_n, addr_strobe, hoe, drv} = {5'b11100, 8'h00};
    // address then data phase, strobes held two clocks
    task automatic access(input logic [7:0] adr, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        @(negedge clk);
        {addr_strobe, hoe, drv} = {2'b11, adr};
        repeat (2) @(negedge clk);
        addr_strobe = 1'b0;
        repeat (2) @(negedge clk);
        {chip_sel_n, hoe, drv, write_n, read_n} = {1'b0, wr, wd, !wr, wr};
        repeat (2) @(negedge clk);
        rd = ad_out;
        {chip_sel_n, read_n, write_n, hoe} = 4'b1110;
        repeat (2) @(negedge clk);
    endtask
endmodule // host_bus_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the rtc registers
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, reset_pin_n, alarm_match, backup_valid, chip_sel_n, addr_strobe, read_n, write_n;
    logic        ad_oe, irq_n_out, irq_n_oe, square_wave_out, osc_run, div_run, update_strobe, buffer_copy_strobe;
    logic        hour_mode_sel, number_format_sel, summer_time_en;
    logic [7:0]  ad_in, ad_out, rd;
    logic [31:0] lfsr = 32'h68AE; // random source
    logic [7:0]  mdl [int];       // register model by offset
    int          err_total = 0, samples_checked = 0, n;
    rtc_control_status_regs DUT (.clk, .rst_n, .reset_pin_n, .chip_sel_n, .addr_strobe, .read_n, .write_n, .ad_in,
        .ad_out, .ad_oe, .irq_n_out, .irq_n_oe, .square_wave_out, .alarm_match, .backup_valid, .osc_run, .div_run,
        .update_strobe, .buffer_copy_strobe, .hour_mode_sel, .number_format_sel, .summer_time_en);
    host_bus_model host (.clk, .ad_out, .ad_oe, .chip_sel_n, .addr_strobe, .read_n, .write_n, .ad_in);
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // model drops pending bit and held update enable
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(a, 1'b1, d, rd);
        if (a == 8'h0A) mdl[a] = {1'b0, d[6:0]};
        if (a == 8'h0B) mdl[a] = d[7] ? d & 8'hEF : d;
    endtask
    task automatic rd_chk(input logic [7:0] a);
        host.access(a, 1'b0, 8'h00, rd);
        chk(rd, mdl[a]);
    endtask
    // square-wave rises over cyc clocks
    task automatic rises(input int cyc, output int r);
        logic p;
        r = 0;
        p = square_wave_out;
        repeat (cyc) begin
            @(negedge clk);
            r += int'(square_wave_out && !p);
            p = square_wave_out;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        test_done();
    end
    // main sequence
    initial begin
        {rst_n, reset_pin_n, alarm_match, backup_valid} = 4'b0101;
        mdl[8'h0A] = 8'h00;
        mdl[8'h0B] = 8'h00;
        mdl[8'h0C] = 8'h00;
        mdl[8'h0D] = 8'h80;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(8'h0A);
        rd_chk(8'h0B);
        rd_chk(8'h0D);
        for (int i = 0; i < 6; i++) begin
            lfsr = next_rand(lfsr);
            wr(8'h0B, lfsr[7:0] | (i == 0 ? 8'h90 : 8'h00));
            rd_chk(8'h0B);
            chk({5'h0, number_format_sel, hour_mode_sel, summer_time_en}, {5'h0, mdl[8'h0B][2:0]});
        end
        for (int s = 0; s < 8; s++) begin
            lfsr = next_rand(lfsr);
            wr(8'h0A, {1'b1, 3'(s), s == 2 ? 4'h0 : lfsr[3:0]});
            rd_chk(8'h0A);
            chk({6'h0, osc_run, div_run}, {6'h0, 1'(s == 2 || s >= 6), 1'(s == 2)});
        end
        backup_valid = 1'b0;
        mdl[8'h0D] = 8'h00;
        wr(8'h0C, 8'hFF);
        wr(8'h0D, 8'hFF);
        wr(8'h1B, 8'h5A);
        host.access(8'h1C, 1'b0, 8'h00, rd);
        rd_chk(8'h0C);
        rd_chk(8'h0D);
        rd_chk(8'h0B);
        wr(8'h0B, 8'h48);
        wr(8'h0A, 8'h23);
        rises(40000, n);
        chk({7'h0, n inside {2, 3}}, 8'h01);
        mdl[8'h0C] = 8'hC0;
        chk({7'h0, irq_n_oe}, 8'h01);
        wr(8'h0A, 8'h63); // hold divider: no event races the clear
        rd_chk(8'h0C);
        mdl[8'h0C] = 8'h00;
        chk({7'h0, irq_n_oe}, 8'h00);
        rd_chk(8'h0C);
        wr(8'h0A, 8'h23);
        wr(8'h0B, 8'hF7);
        rises(8000, n);
        chk({7'h0, n == 0 && !square_wave_out}, 8'h01);
        rd_chk(8'h0B);
        wr(8'h0A, 8'h00);
        reset_pin_n = 1'b0;
        @(negedge clk);
        reset_pin_n = 1'b1;
        mdl[8'h0B] = mdl[8'h0B] & 8'h87;
        chk({7'h0, irq_n_oe}, 8'h00);
        rd_chk(8'h0B);
        rd_chk(8'h0C);
        test_done();
    end
endmodule // testbench
`default_nettype wire
